// File: src/cmpa_regs.svh
`ifndef CMPA_REGS_SVH
`define CMPA_REGS_SVH

// register map, byte addresses on the register bus
`define CMPA_TUNE_ADDR      32'h482af400
`define CMPA_STAT_ADDR      32'h482af404
`define CMPA_TUNE_RST       32'h00000000
`define CMPA_TUNE_ADVISED   32'h00000006
`define CMPA_TUNE_GUARD_BIT 1
`define CMPA_TUNE_SER_BIT   2

// status register fields
`define CMPA_STAT_HUNG      0
`define CMPA_STAT_HEAVY     1
`define CMPA_STAT_LL0_BUSY  2
`define CMPA_STAT_LL1_BUSY  3
`define CMPA_STAT_IC_BUSY   4
`define CMPA_STAT_HOLD      5

// bus answers
`define CMPA_RESP_OKAY      2'h0
`define CMPA_RESP_SLVERR    2'h2

// host address decode
`define CMPA_DDR_BIT        31
`define CMPA_ILV_BIT        7
`define CMPA_WIN_HI         31
`define CMPA_WIN_LO         24
`define CMPA_TILED_HI       31
`define CMPA_TILED_LO       29
`define CMPA_TILED_TAG      3'h3
`define CMPA_MGR_TAG        8'h4e
`define CMPA_CTRL_TAG       8'h4c

// interconnect load: busy cycles counted as heavy
`define CMPA_HEAVY_CNT      8'h10
`define CMPA_CNT_ONE        8'h01
`define CMPA_CNT_MAX        8'hff

`endif

// File: src/cmpa_pkg.sv
package cmpa_pkg;

    // route port sequencing
    typedef enum logic [1:0] {
        RP_IDLE,
        RP_REQ,
        RP_WAIT,
        RP_DONE
    } port_state_type;

    // route index toward the host response
    typedef enum logic [1:0] {
        ROUTE_LL0,
        ROUTE_LL1,
        ROUTE_IC
    } route_type;

endpackage : cmpa_pkg

// File: src/cmpa_route_port.sv
`timescale 1ns/1ps

// one route toward a downstream target, one transaction at a time
module cmpa_route_port (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        freeze,
    input  wire logic        start,
    input  wire logic [31:0] start_addr,
    input  wire logic        start_write,
    input  wire logic [31:0] start_wdata,
    input  wire logic        take,
    output logic             busy,
    output logic             done,
    output logic [31:0]      done_rdata,
    output logic             dn_valid,
    input  wire logic        dn_ready,
    output logic [31:0]      dn_addr,
    output logic             dn_write,
    output logic [31:0]      dn_wdata,
    input  wire logic        dn_rsp_valid,
    input  wire logic [31:0] dn_rsp_rdata
);
    cmpa_pkg::port_state_type state_r, state_nxt;
    logic        busy_nxt, done_nxt, valid_nxt, write_nxt;
    logic [31:0] rdata_nxt, addr_nxt, wdata_nxt;

    // next state; freeze stops every move so a hang stays a hang
    always_comb begin
        state_nxt = state_r;
        rdata_nxt = done_rdata;
        addr_nxt  = dn_addr;
        write_nxt = dn_write;
        wdata_nxt = dn_wdata;
        if (!freeze) begin
            unique case (state_r)
                cmpa_pkg::RP_IDLE: if (start) begin
                    state_nxt = cmpa_pkg::RP_REQ;
                    addr_nxt  = start_addr;
                    write_nxt = start_write;
                    wdata_nxt = start_wdata;
                end
                cmpa_pkg::RP_REQ: if (dn_ready) begin
                    state_nxt = cmpa_pkg::RP_WAIT;
                end
                cmpa_pkg::RP_WAIT: if (dn_rsp_valid) begin
                    state_nxt = cmpa_pkg::RP_DONE;
                    rdata_nxt = dn_rsp_rdata;
                end
                cmpa_pkg::RP_DONE: if (take) begin
                    state_nxt = cmpa_pkg::RP_IDLE;
                end
            endcase
        end
        busy_nxt  = (state_nxt != cmpa_pkg::RP_IDLE);
        done_nxt  = (state_nxt == cmpa_pkg::RP_DONE);
        valid_nxt = (state_nxt == cmpa_pkg::RP_REQ);
    end

    // registers; valid holds with its payload until ready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r    <= cmpa_pkg::RP_IDLE;
            busy       <= 1'b0;
            done       <= 1'b0;
            done_rdata <= '0;
            dn_valid   <= 1'b0;
            dn_addr    <= '0;
            dn_write   <= 1'b0;
            dn_wdata   <= '0;
        end else begin
            state_r    <= state_nxt;
            busy       <= busy_nxt;
            done       <= done_nxt;
            done_rdata <= rdata_nxt;
            dn_valid   <= valid_nxt;
            dn_addr    <= addr_nxt;
            dn_write   <= write_nxt;
            dn_wdata   <= wdata_nxt;
        end
    end

endmodule : cmpa_route_port

// File: src/cmpa_adapter.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "cmpa_regs.svh"

module cmpa_adapter (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // register bus
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // host processor
    input  wire logic        hp_req_valid,
    output logic             hp_req_ready,
    input  wire logic [31:0] hp_req_addr,
    input  wire logic        hp_req_write,
    input  wire logic [31:0] hp_req_wdata,
    output logic             hp_rsp_valid,
    output logic [1:0]       hp_rsp_route,
    output logic [31:0]      hp_rsp_rdata,
    // low-latency route, controller 0
    output logic             ll0_valid,
    input  wire logic        ll0_ready,
    output logic [31:0]      ll0_addr,
    output logic             ll0_write,
    output logic [31:0]      ll0_wdata,
    input  wire logic        ll0_rsp_valid,
    input  wire logic [31:0] ll0_rsp_rdata,
    // low-latency route, controller 1
    output logic             ll1_valid,
    input  wire logic        ll1_ready,
    output logic [31:0]      ll1_addr,
    output logic             ll1_write,
    output logic [31:0]      ll1_wdata,
    input  wire logic        ll1_rsp_valid,
    input  wire logic [31:0] ll1_rsp_rdata,
    // interconnect route through the axi_to_ocp_bridge
    output logic             ic_valid,
    input  wire logic        ic_ready,
    output logic [31:0]      ic_addr,
    output logic             ic_write,
    output logic [31:0]      ic_wdata,
    input  wire logic        ic_rsp_valid,
    input  wire logic [31:0] ic_rsp_rdata,
    // device state
    output logic             hung
);
    ////////////////////////////////////////////////////////////////////////
    // state
    logic        hold_v_r, hold_v_nxt, hold_w_r, hold_w_nxt;
    logic [31:0] hold_a_r, hold_a_nxt, hold_d_r, hold_d_nxt;
    logic        ready_nxt, hung_nxt, rsp_v_nxt;
    logic [1:0]  rsp_route_nxt;
    logic [31:0] rsp_data_nxt;
    logic [2:0]  cur_w_r, cur_w_nxt;
    logic        ic_prot_r, ic_prot_nxt;
    logic [7:0]  ic_cnt_r, ic_cnt_nxt;
    logic [31:0] tune_r, tune_nxt;
    logic [2:0]  r_busy, r_done, r_start, r_take;
    logic [31:0] r_rdata [3];

    // decode of the held request
    logic is_ddr, is_tiled, is_mgr, is_ctrl, is_prot, ll_sel;
    logic ll_wr_out, ic_pwr_out, heavy, overlap, blocked, go;
    logic guard_en, ser_en;

    assign guard_en = tune_r[`CMPA_TUNE_GUARD_BIT];
    assign ser_en   = tune_r[`CMPA_TUNE_SER_BIT];

    // address classes
    always_comb begin
        is_ddr   = hold_a_r[`CMPA_DDR_BIT];
        is_tiled = (hold_a_r[`CMPA_TILED_HI:`CMPA_TILED_LO]
                    == `CMPA_TILED_TAG);
        is_mgr   = (hold_a_r[`CMPA_WIN_HI:`CMPA_WIN_LO] == `CMPA_MGR_TAG);
        is_ctrl  = (hold_a_r[`CMPA_WIN_HI:`CMPA_WIN_LO] == `CMPA_CTRL_TAG);
        is_prot  = is_tiled || is_mgr || is_ctrl;
        ll_sel   = hold_a_r[`CMPA_ILV_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // routing, guard and hang
    always_comb begin
        ll_wr_out  = (r_busy[0] && cur_w_r[0]) || (r_busy[1] && cur_w_r[1]);
        ic_pwr_out = r_busy[2] && cur_w_r[2] && ic_prot_r;
        heavy      = (ic_cnt_r >= `CMPA_HEAVY_CNT);
        // the defect: both routes writing protected and ddr space at once while the interconnect is heavy
        overlap    = heavy && ll_wr_out && ic_pwr_out;
        hung_nxt   = hung || overlap;
        // guard both ways; the serial bit covers the ddr side
        blocked = (guard_en && !is_ddr && is_prot && hold_w_r
                   && ll_wr_out)
               || (ser_en && is_ddr && hold_w_r && ic_pwr_out);
        go      = hold_v_r && !blocked && !hung_nxt;
        r_start = 3'h0;
        if (go && is_ddr && !r_busy[ll_sel]) begin
            r_start[ll_sel] = 1'b1;
        end else if (go && !is_ddr && !r_busy[2]) begin
            r_start[2] = 1'b1;
        end
    end

    // host side hold stage and per-route bookkeeping
    always_comb begin
        hold_v_nxt = hold_v_r;
        hold_w_nxt = hold_w_r;
        hold_a_nxt = hold_a_r;
        hold_d_nxt = hold_d_r;
        cur_w_nxt  = cur_w_r;
        ic_prot_nxt = ic_prot_r;
        if (r_start != 3'h0) begin
            hold_v_nxt = 1'b0;
        end
        for (int i = 0; i < 3; i++) begin
            if (r_start[i]) begin
                cur_w_nxt[i] = hold_w_r;
            end
        end
        if (r_start[2]) begin
            ic_prot_nxt = is_prot;
        end
        if (hp_req_valid && hp_req_ready) begin
            hold_v_nxt = 1'b1;
            hold_w_nxt = hp_req_write;
            hold_a_nxt = hp_req_addr;
            hold_d_nxt = hp_req_wdata;
        end
        // a hung adapter takes no new work
        ready_nxt = !hold_v_nxt && !hung_nxt;
        // interconnect load: consecutive busy cycles, saturating
        if (!r_busy[2]) begin
            ic_cnt_nxt = '0;
        end else if (ic_cnt_r != `CMPA_CNT_MAX) begin
            ic_cnt_nxt = ic_cnt_r + `CMPA_CNT_ONE;
        end else begin
            ic_cnt_nxt = ic_cnt_r;
        end
    end

    // response pick, fixed priority, none once hung
    always_comb begin
        r_take        = 3'h0;
        rsp_v_nxt     = 1'b0;
        rsp_route_nxt = hp_rsp_route;
        rsp_data_nxt  = hp_rsp_rdata;
        if (!hung_nxt) begin
            for (int i = 2; i >= 0; i--) begin
                if (r_done[i]) begin
                    r_take        = 3'h0;
                    r_take[i]     = 1'b1;
                    rsp_v_nxt     = 1'b1;
                    rsp_route_nxt = 2'(i);
                    rsp_data_nxt  = r_rdata[i];
                end
            end
        end
    end

    // only reset clears the hang
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_v_r     <= 1'b0;
            hold_w_r     <= 1'b0;
            hold_a_r     <= '0;
            hold_d_r     <= '0;
            hp_req_ready <= 1'b0;
            hung         <= 1'b0;
            cur_w_r      <= 3'h0;
            ic_prot_r    <= 1'b0;
            ic_cnt_r     <= '0;
            hp_rsp_valid <= 1'b0;
            hp_rsp_route <= 2'h0;
            hp_rsp_rdata <= '0;
        end else begin
            hold_v_r     <= hold_v_nxt;
            hold_w_r     <= hold_w_nxt;
            hold_a_r     <= hold_a_nxt;
            hold_d_r     <= hold_d_nxt;
            hp_req_ready <= ready_nxt;
            hung         <= hung_nxt;
            cur_w_r      <= cur_w_nxt;
            ic_prot_r    <= ic_prot_nxt;
            ic_cnt_r     <= ic_cnt_nxt;
            hp_rsp_valid <= rsp_v_nxt;
            hp_rsp_route <= rsp_route_nxt;
            hp_rsp_rdata <= rsp_data_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // the three route ports; a hang freezes all of them
    cmpa_route_port u_ll0 (
        .aclk(aclk), .aresetn(aresetn), .freeze(hung_nxt),
        .start(r_start[0]), .start_addr(hold_a_r),
        .start_write(hold_w_r), .start_wdata(hold_d_r),
        .take(r_take[0]), .busy(r_busy[0]), .done(r_done[0]),
        .done_rdata(r_rdata[0]), .dn_valid(ll0_valid),
        .dn_ready(ll0_ready), .dn_addr(ll0_addr), .dn_write(ll0_write),
        .dn_wdata(ll0_wdata), .dn_rsp_valid(ll0_rsp_valid),
        .dn_rsp_rdata(ll0_rsp_rdata));

    cmpa_route_port u_ll1 (
        .aclk(aclk), .aresetn(aresetn), .freeze(hung_nxt),
        .start(r_start[1]), .start_addr(hold_a_r),
        .start_write(hold_w_r), .start_wdata(hold_d_r),
        .take(r_take[1]), .busy(r_busy[1]), .done(r_done[1]),
        .done_rdata(r_rdata[1]), .dn_valid(ll1_valid),
        .dn_ready(ll1_ready), .dn_addr(ll1_addr), .dn_write(ll1_write),
        .dn_wdata(ll1_wdata), .dn_rsp_valid(ll1_rsp_valid),
        .dn_rsp_rdata(ll1_rsp_rdata));

    cmpa_route_port u_ic (
        .aclk(aclk), .aresetn(aresetn), .freeze(hung_nxt),
        .start(r_start[2]), .start_addr(hold_a_r),
        .start_write(hold_w_r), .start_wdata(hold_d_r),
        .take(r_take[2]), .busy(r_busy[2]), .done(r_done[2]),
        .done_rdata(r_rdata[2]), .dn_valid(ic_valid),
        .dn_ready(ic_ready), .dn_addr(ic_addr), .dn_write(ic_write),
        .dn_wdata(ic_wdata), .dn_rsp_valid(ic_rsp_valid),
        .dn_rsp_rdata(ic_rsp_rdata));

    ////////////////////////////////////////////////////////////////////////
    // register bus slave; keeps answering while hung so status is visible
    logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [31:0] wa_r, wa_nxt, wd_r, wd_nxt;
    logic [3:0]  ws_r, ws_nxt;
    logic        awr_nxt, wr_nxt, bv_nxt, arr_nxt, rv_nxt;
    logic [1:0]  bresp_nxt, rresp_nxt;
    logic [31:0] rdata_nxt, stat_w;

    always_comb begin
        stat_w = '0;
        stat_w[`CMPA_STAT_HUNG]     = hung;
        stat_w[`CMPA_STAT_HEAVY]    = heavy;
        stat_w[`CMPA_STAT_LL0_BUSY] = r_busy[0];
        stat_w[`CMPA_STAT_LL1_BUSY] = r_busy[1];
        stat_w[`CMPA_STAT_IC_BUSY]  = r_busy[2];
        stat_w[`CMPA_STAT_HOLD]     = hold_v_r;
    end

    // address and data may come in either order
    always_comb begin
        aw_got_nxt = aw_got_r;
        w_got_nxt  = w_got_r;
        wa_nxt = wa_r;
        wd_nxt = wd_r;
        ws_nxt = ws_r;
        tune_nxt  = tune_r;
        bv_nxt    = s_axi_bvalid && !s_axi_bready;
        bresp_nxt = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_nxt = 1'b1;
            wa_nxt     = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_nxt = 1'b1;
            wd_nxt    = s_axi_wdata;
            ws_nxt    = s_axi_wstrb;
        end
        if (aw_got_nxt && w_got_nxt && !bv_nxt) begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bv_nxt     = 1'b1;
            bresp_nxt  = `CMPA_RESP_SLVERR;
            if (wa_nxt == `CMPA_TUNE_ADDR) begin
                bresp_nxt = `CMPA_RESP_OKAY;
                for (int b = 0; b < 4; b++) begin
                    if (ws_nxt[b]) begin
                        tune_nxt[8*b +: 8] = wd_nxt[8*b +: 8];
                    end
                end
            end else if (wa_nxt == `CMPA_STAT_ADDR) begin
                bresp_nxt = `CMPA_RESP_OKAY;
            end
        end
        awr_nxt = !aw_got_nxt;
        wr_nxt  = !w_got_nxt;
        // read side: one read at a time
        rv_nxt    = s_axi_rvalid && !s_axi_rready;
        rresp_nxt = s_axi_rresp;
        rdata_nxt = s_axi_rdata;
        if (s_axi_arvalid && s_axi_arready) begin
            rv_nxt    = 1'b1;
            rresp_nxt = `CMPA_RESP_OKAY;
            rdata_nxt = '0;
            if (s_axi_araddr == `CMPA_TUNE_ADDR) begin
                rdata_nxt = tune_r;
            end else if (s_axi_araddr == `CMPA_STAT_ADDR) begin
                rdata_nxt = stat_w;
            end else begin
                rresp_nxt = `CMPA_RESP_SLVERR;
            end
        end
        arr_nxt = !rv_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            wa_r          <= '0;
            wd_r          <= '0;
            ws_r          <= 4'h0;
            tune_r        <= `CMPA_TUNE_RST;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CMPA_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `CMPA_RESP_OKAY;
            s_axi_rdata   <= '0;
        end else begin
            aw_got_r      <= aw_got_nxt;
            w_got_r       <= w_got_nxt;
            wa_r          <= wa_nxt;
            wd_r          <= wd_nxt;
            ws_r          <= ws_nxt;
            tune_r        <= tune_nxt;
            s_axi_awready <= awr_nxt;
            s_axi_wready  <= wr_nxt;
            s_axi_bvalid  <= bv_nxt;
            s_axi_bresp   <= bresp_nxt;
            s_axi_arready <= arr_nxt;
            s_axi_rvalid  <= rv_nxt;
            s_axi_rresp   <= rresp_nxt;
            s_axi_rdata   <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_tune_read;
        s_ar_taken and (s_axi_araddr == `CMPA_TUNE_ADDR);
    endsequence

    a_one_route: assert property ($onehot0(r_start))
        else $error("request started on two routes");
    a_ll_interleave: assert property (r_start[0] || r_start[1]
        |-> is_ddr && r_start[ll_sel])
        else $error("ddr request sent to wrong controller");
    a_ic_nonddr: assert property (r_start[2] |-> !is_ddr)
        else $error("ddr request sent to interconnect");
    a_hang_cause: assert property ($rose(hung) |-> $past(overlap))
        else $error("hang without overlapping writes");
    a_hang_quiet: assert property (hung |-> ##1
        (!hp_req_ready && !hp_rsp_valid && r_start == 3'h0)[*2])
        else $error("hung adapter still moving traffic");
    a_hang_sticky: assert property (hung |=> hung)
        else $error("hang cleared without reset");
    a_tune_readback: assert property (s_tune_read |=>
        s_axi_rvalid && s_axi_rresp == `CMPA_RESP_OKAY
        && s_axi_rdata == $past(tune_r))
        else $error("tuning register read wrong");
    a_tune_write: assert property ($rose(s_axi_bvalid)
        && wa_r == `CMPA_TUNE_ADDR && ws_r == 4'hf
        |-> tune_r == wd_r && s_axi_bresp == `CMPA_RESP_OKAY)
        else $error("tuning write not stored");
    a_guard_hold: assert property (guard_en && hold_v_r && hold_w_r
        && !is_ddr && is_prot && ll_wr_out |-> !r_start[2])
        else $error("protected write overlapped ddr write");

endmodule : cmpa_adapter

// File: verification/cmpa_far_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// far-side target: takes a request after lag cycles, answers next cycle
module cmpa_far_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  lag,
    input  wire logic        valid,
    input  wire logic [31:0] addr,
    input  wire logic        write,
    input  wire logic [31:0] wdata,
    output logic             ready,
    output logic             rsp_valid,
    output logic [31:0]      rsp_rdata
);
    logic [7:0]  cnt_r;
    logic        pend_r;
    logic [31:0] data_r;
    // idle read data toggles so a stale word never looks like an answer
    always_ff @(posedge aclk) begin
        ready     <= 1'b0;
        pend_r    <= 1'b0;
        rsp_valid <= pend_r;
        rsp_rdata <= pend_r ? data_r : ~rsp_rdata;
        if (valid && !ready && !pend_r) begin
            cnt_r <= cnt_r + 8'h01;
            if (cnt_r == lag) begin
                ready  <= 1'b1;
                pend_r <= 1'b1;
                cnt_r  <= 8'h00;
                // writes echo their payload so write data is checked too
                data_r <= write ? wdata : (addr ^ 32'h00ff00ff);
            end
        end
        if (!aresetn) begin
            cnt_r     <= 8'h00;
            ready     <= 1'b0;
            pend_r    <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 32'h00000000;
        end
    end
endmodule : cmpa_far_model

// File: verification/testbench.sv
`timescale 1ns/1ps
`include "cmpa_regs.svh"
module testbench;
    logic        aclk = 1'b0, aresetn = 1'b0, hung;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_rvalid;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, hp_rsp_route, r;
    logic [31:0] s_axi_rdata, hp_rsp_rdata, rd, hp_req_addr = '0;
    logic        hp_req_valid = 0, hp_req_write = 0, hp_req_ready;
    logic [31:0] hp_req_wdata = '0, ll0_addr, ll1_addr, ic_addr;
    logic [31:0] ll0_wdata, ll1_wdata, ic_wdata, ll0_rsp_rdata;
    logic [31:0] ll1_rsp_rdata, ic_rsp_rdata;
    logic        hp_rsp_valid, ll0_valid, ll1_valid, ic_valid, ll0_write;
    logic        ll1_write, ic_write, ll0_ready, ll1_ready, ic_ready;
    logic        ll0_rsp_valid, ll1_rsp_valid, ic_rsp_valid;
    logic [7:0]  ll_lag = 8'h02, ic_lag = 8'h02;
    logic [33:0] rsp_q[$];
    int          err_total = 0, num_checks = 0;
    always #20 aclk = ~aclk;
    cmpa_adapter u_cmpa_adapter (.*);
    cmpa_far_model u_ll0 (.aclk, .aresetn, .lag(ll_lag), .valid(ll0_valid),
        .addr(ll0_addr), .write(ll0_write), .wdata(ll0_wdata),
        .ready(ll0_ready), .rsp_valid(ll0_rsp_valid),
        .rsp_rdata(ll0_rsp_rdata));
    cmpa_far_model u_ll1 (.aclk, .aresetn, .lag(ll_lag), .valid(ll1_valid),
        .addr(ll1_addr), .write(ll1_write), .wdata(ll1_wdata),
        .ready(ll1_ready), .rsp_valid(ll1_rsp_valid),
        .rsp_rdata(ll1_rsp_rdata));
    cmpa_far_model u_ic (.aclk, .aresetn, .lag(ic_lag), .valid(ic_valid),
        .addr(ic_addr), .write(ic_write), .wdata(ic_wdata),
        .ready(ic_ready), .rsp_valid(ic_rsp_valid),
        .rsp_rdata(ic_rsp_rdata));
    // completions are one-cycle pulses, so catch every one
    always @(posedge aclk) if (hp_rsp_valid === 1'b1)
        rsp_q.push_back({hp_rsp_route, hp_rsp_rdata});
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test
    // each channel dropped at its own handshake edge
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        if (s_axi_bvalid !== 1'b1) err_total++;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        // one idle edge so the next call never re-raises bready at once
        @(posedge aclk);
    endtask : axi_wr
    task automatic axi_rd(input logic [31:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        if (s_axi_rvalid !== 1'b1) err_total++;
        r = s_axi_rresp;
        rd = s_axi_rdata;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_rd
    task automatic hp_send(input logic [31:0] a, input logic w);
        int n;
        n = 0;
        hp_req_addr <= a;
        hp_req_write <= w;
        hp_req_wdata <= ~a;
        hp_req_valid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (hp_req_ready !== 1'b1 && n < 300);
        if (hp_req_ready !== 1'b1) err_total++;
        hp_req_valid <= 1'b0;
        @(posedge aclk);
    endtask : hp_send
    // pops the next completion; reads carry the address pattern, writes
    // echo their payload
    task automatic hp_expect(input logic [1:0] rt, input logic [31:0] a,
                             input logic w);
        int n;
        n = 0;
        while (rsp_q.size() == 0 && n < 400) begin
            @(posedge aclk);
            n++;
        end
        if (rsp_q.size() == 0) rsp_q.push_back('1);
        check({30'h0, rsp_q[0][33:32]}, {30'h0, rt});
        check(rsp_q[0][31:0], w ? ~a : a ^ 32'h00ff00ff);
        void'(rsp_q.pop_front());
    endtask : hp_expect
    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////
    // route table: ddr interleave, plain, manager, controller, tiled
    logic [31:0] addr_t[6] = '{32'h80000000, 32'h80000080, 32'h10000000,
                               32'h4e000010, 32'h4c000020, 32'h60000000};
    logic [1:0]  route_t[6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2};
    initial begin
        do_reset;
        axi_rd(`CMPA_TUNE_ADDR);
        check(rd, `CMPA_TUNE_RST);
        check({30'h0, r}, {30'h0, `CMPA_RESP_OKAY});
        axi_rd(32'h482af408);
        check({30'h0, r}, {30'h0, `CMPA_RESP_SLVERR});
        for (int i = 0; i < 6; i++) begin
            hp_send(addr_t[i], 1'b0);
            hp_expect(route_t[i], addr_t[i], 1'b0);
        end
        // heavy load, ddr write beside a plain interconnect write: plain
        // space is outside manager, controller and tiled space, no hang
        ll_lag <= 8'h28;
        ic_lag <= 8'h28;
        hp_send(32'h10000000, 1'b1);
        hp_send(32'h80000000, 1'b1);
        hp_expect(2'h2, 32'h10000000, 1'b1);
        hp_expect(2'h0, 32'h80000000, 1'b1);
        check({31'h0, hung}, 32'h0);
        // overlapping protected writes under load, guard off: hang
        hp_send(32'h4c000000, 1'b1);
        hp_send(32'h80000000, 1'b1);
        repeat (80) @(posedge aclk);
        check({31'h0, hung}, 32'h1);
        check({31'h0, hp_req_ready}, 32'h0);
        axi_rd(`CMPA_STAT_ADDR);
        check({31'h0, rd[`CMPA_STAT_HUNG]}, 32'h1);
        do_reset;
        rsp_q.delete();
        check({31'h0, hung}, 32'h0);
        // guard on: interconnect write waits for the ddr write
        axi_wr(`CMPA_TUNE_ADDR, `CMPA_TUNE_ADVISED);
        check({30'h0, r}, {30'h0, `CMPA_RESP_OKAY});
        axi_rd(`CMPA_TUNE_ADDR);
        check(rd, 32'h00000006);
        hp_send(32'h80000000, 1'b1);
        hp_send(32'h4c000000, 1'b1);
        hp_expect(2'h0, 32'h80000000, 1'b1);
        hp_expect(2'h2, 32'h4c000000, 1'b1);
        check({31'h0, hung}, 32'h0);
        finish_test;
    end
    // watchdog, far beyond the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        finish_test;
    end
endmodule : testbench
